/* bench/servo_enable_and_completion_status_tb_top.sv */
`include "servo_status_defs.vh"
`default_nettype none

// ==========================================================================
// Testbench for the servo enable and completion status block.
// ==========================================================================
module servo_enable_and_completion_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] posError = 16'h0000;
    logic [15:0] speedRef = 16'h0000;
    logic [15:0] speedActual = 16'h0000;
    logic        runningIn = 1'b0;
    logic        readyIn = 1'b0;
    logic        estopReq = 1'b1;
    logic [15:0] regRdData, speedCmdOut;
    logic        enableInN, controlTick, motorOn, positionDoneOutN, speedMatchOutN;
    logic [2:0]  pairOutN;
    int          nErrors = 0;
    int          cmpCount = 0;
    logic [7:0]  pw [8] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h00, 8'h00, 8'hfa, 8'hfa};
    logic [15:0] pe [8] = '{16'h0007, 16'hfff9, 16'h0008, 16'hfff8,
                            16'h0000, 16'h0001, 16'h00fa, 16'hff05};
    logic        pd [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] sa [5] = '{16'h076c, 16'h0834, 16'h076b, 16'h0835, 16'h0032};
    logic [15:0] sr [5] = '{16'h07d0, 16'h07d0, 16'h07d0, 16'h07d0, 16'hffce};
    logic        sm [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    servo_status_core u_dut (
        .ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .enableInN, .controlTick, .posError, .speedRef, .speedActual,
        .runningIn, .readyIn, .motorOn, .speedCmdOut, .positionDoneOutN,
        .speedMatchOutN, .pairOutN
    );
    servo_host_model u_host (.ref_clk, .rst, .estopReq, .enableInN, .controlTick);

    // Verdict and end of run.
    task automatic endSim;
        if (nErrors == 0 && cmpCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            nErrors++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk(name, exp, regRdData);
    endtask

    // Apply the inputs, find the next control tick, look two edges later.
    task automatic status(input logic [15:0] p, r, s, input logic d, m,
                          input logic [2:0] q);
        @(posedge ref_clk);
        posError    <= p;
        speedRef    <= r;
        speedActual <= s;
        @(posedge ref_clk);
        while (controlTick !== 1'b1)
            @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        #1 chk("outs", 16'({d, m, q}), 16'({positionDoneOutN, speedMatchOutN, pairOutN}));
    endtask

    // Free running clock.
    initial
        forever #5 ref_clk = ~ref_clk;

    // Hang guard.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        nErrors++;
        endSim;
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`OFS_CTRL, 16'h0001, "ctrl");
        rd(`OFS_POS_WIDTH, 16'h0007, "posWidth");
        rd(`OFS_SPD_WIDTH, 16'h000a, "spdWidth");
        rd(`OFS_OUT_SEL, 16'h3211, "outSel");
        rd(4'hf, 16'h0000, "unmapped");
        wr(`OFS_POS_WIDTH, 16'h00fb);
        rd(`OFS_POS_WIDTH, 16'h00fa, "posWidth");
        wr(`OFS_SPD_WIDTH, 16'h0065);
        rd(`OFS_SPD_WIDTH, 16'h0064, "spdWidth");
        // Enable pin on, then emergency release, then forced on.
        @(posedge ref_clk);
        estopReq <= 1'b0;
        speedRef <= 16'h0064;
        repeat (5) @(posedge ref_clk);
        #1 chk("motorOn", 16'h0001, 16'(motorOn));
        chk("speedCmdOut", 16'h0064, speedCmdOut);
        @(posedge ref_clk);
        estopReq <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 chk("motorOn", 16'h0000, 16'(motorOn));
        chk("speedCmdOut", 16'h0000, speedCmdOut);
        wr(`OFS_CTRL, 16'h0071);
        repeat (3) @(posedge ref_clk);
        #1 chk("motorOn", 16'h0001, 16'(motorOn));
        wr(`OFS_CTRL, 16'h0001);
        // Position error around the width, both signs and both ends of range.
        foreach (pw[i])
        begin
            wr(`OFS_POS_WIDTH, 16'(pw[i]));
            status(pe[i], 16'h0000, 16'h0000, pd[i], 1'b1, {2'h3, pd[i]});
        end
        // Speed difference around the width in speed control.
        wr(`OFS_CTRL, 16'h0000);
        foreach (sr[i])
            status(16'h0000, sr[i], sa[i], 1'b1, sm[i], {2'h3, sm[i]});
        // Torque control holds the shared output on.
        wr(`OFS_CTRL, 16'h0002);
        status(16'h7fff, 16'h07d0, 16'h0000, 1'b0, 1'b0, 3'h6);
        // The status offset is read only; a write there changes nothing.
        wr(`OFS_STATUS, 16'hffff);
        rd(`OFS_STATUS, 16'h0010, "status");
        // Two sources on one pair are ORed; an unallocated source stays off.
        wr(`OFS_CTRL, 16'h0000);
        wr(`OFS_OUT_SEL, 16'h0221);
        runningIn <= 1'b1;
        readyIn   <= 1'b1;
        status(16'h0000, 16'h07d0, 16'h0000, 1'b1, 1'b1, 3'h5);
        @(posedge ref_clk);
        runningIn <= 1'b0;
        status(16'h0000, 16'h07d0, 16'h0000, 1'b1, 1'b1, 3'h7);
        status(16'h0000, 16'h07d0, 16'h07d0, 1'b1, 1'b0, 3'h5);
        endSim;
    end
endmodule // servo_enable_and_completion_status_tb_top

`default_nettype wire

/* bench/servo_host_model.sv */
`default_nettype none

// ==========================================================================
// Host controller: control cycle strobe and the enable pin.
// ==========================================================================
module servo_host_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic estopReq,
    output var  logic enableInN = 1'b1,
    output var  logic controlTick = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] tickCnt = 2'h0;

    // One control cycle every fourth clock, quiet during reset.
    always @(posedge ref_clk)
    begin
        tickCnt     <= rst ? 2'h0 : tickCnt + 2'h1;
        controlTick <= !rst && tickCnt == 2'h3;
    end

    // Motion is run by references; the pin is released only in reset or on an emergency.
    always @(posedge ref_clk)
        enableInN <= rst | estopReq;
endmodule // servo_host_model

`default_nettype wire

/* bench/servo_status_assertions.sv */
`include "servo_status_defs.vh"
`default_nettype none

// ==========================================================================
// Port checker for the servo status core.
// ==========================================================================
module servo_status_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWr,
    input wire logic        enableInN,
    input wire logic        controlTick,
    input wire logic [15:0] posError,
    input wire logic [15:0] speedRef,
    input wire logic [15:0] speedActual,
    input wire logic        motorOn,
    input wire logic [15:0] speedCmdOut,
    input wire logic        positionDoneOutN,
    input wire logic        speedMatchOutN,
    input wire logic [2:0]  pairOutN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0]  modeReg;
    logic [3:0]  mapReg;
    logic [7:0]  posWReg;
    logic [6:0]  spdWReg;
    logic [15:0] selReg;
    logic [16:0] posExt;
    logic [16:0] spdExt;
    logic        posIn;
    logic        spdIn;

    // Shadow of the settings, saturated the way the core does it.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            modeReg <= `RST_MODE;
            mapReg  <= `RST_MAP;
            posWReg <= `RST_POS_WIDTH;
            spdWReg <= `RST_SPD_WIDTH;
            selReg  <= `RST_OUT_SEL;
        end
        else if (regWr)
        begin
            if (regAddr == `OFS_CTRL)
            begin
                modeReg <= regWrData[1:0];
                mapReg  <= regWrData[7:4];
            end
            if (regAddr == `OFS_POS_WIDTH)
                posWReg <= (regWrData[7:0] > 8'hfa) ? `MAX_POS_WIDTH : regWrData[7:0];
            if (regAddr == `OFS_SPD_WIDTH)
                spdWReg <= (regWrData[7:0] > 8'h64) ? `MAX_SPD_WIDTH : regWrData[6:0];
            if (regAddr == `OFS_OUT_SEL)
                selReg <= regWrData;
        end
    end

    // Magnitude of the position error and of the speed difference.
    assign posExt = {posError[15], posError};
    assign spdExt = {speedRef[15], speedRef} - {speedActual[15], speedActual};
    assign posIn  = (posExt[16] ? -posExt : posExt) <= {9'h0, posWReg};
    assign spdIn  = (spdExt[16] ? -spdExt : spdExt) <= {10'h0, spdWReg};

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // A tick with no setting written beside it; its result shows one edge later.
    sequence tickIn(logic [1:0] m);
        controlTick && !regWr && modeReg == m ##1 !regWr;
    endsequence

    AST_OFF_NO_CMD: assert property (
        !motorOn |-> speedCmdOut == 16'h0000)
        else $error("speed command while motor off");
    AST_ON_FOLLOWS: assert property (
        motorOn && $past(motorOn) && $stable(speedRef) |-> speedCmdOut == speedRef)
        else $error("speed command does not follow reference");
    AST_PIN_OFF: assert property (
        (enableInN && mapReg == `MAP_PIN) [*4] |=> !motorOn)
        else $error("motor on with enable pin released");
    AST_PIN_ON: assert property (
        (!enableInN && mapReg == `MAP_PIN) [*4] |=> motorOn)
        else $error("motor off with enable pin asserted");
    AST_FORCED_ON: assert property (
        (mapReg == `MAP_FORCED_ON) [*2] |=> motorOn)
        else $error("motor off with forced enable mapping");
    AST_POS_DONE: assert property (
        tickIn(`MODE_POSITION) |=> positionDoneOutN == !$past(posIn, 2))
        else $error("position done wrong");
    AST_SPD_MATCH: assert property (
        tickIn(`MODE_SPEED) |=> speedMatchOutN == !$past(spdIn, 2))
        else $error("speed match wrong");
    AST_TORQUE_ON: assert property (
        tickIn(`MODE_TORQUE) |=> !positionDoneOutN && !speedMatchOutN)
        else $error("status not held in torque control");
    AST_FACTORY_PAIR: assert property (
        tickIn(`MODE_POSITION) ##0 selReg == `RST_OUT_SEL |=> pairOutN[0] == positionDoneOutN)
        else $error("first pair does not carry position done");
    AST_HOLD_BETWEEN: assert property (
        !$past(controlTick, 2) && !$past(regWr) && !$past(regWr, 2)
        |-> $stable(positionDoneOutN) && $stable(pairOutN))
        else $error("status changed between control cycles");

    cover property (tickIn(`MODE_SPEED) |=> !speedMatchOutN);
    cover property (tickIn(`MODE_POSITION) |=> !positionDoneOutN);
    cover property (motorOn && mapReg == `MAP_FORCED_ON);
endmodule // servo_status_checker

bind servo_status_core servo_status_checker u_checker (
    .ref_clk, .rst, .regAddr, .regWrData, .regWr, .enableInN, .controlTick,
    .posError, .speedRef, .speedActual, .motorOn, .speedCmdOut,
    .positionDoneOutN, .speedMatchOutN, .pairOutN
);

`default_nettype wire

/* src/mag_within_width.v */
`default_nettype none

// ==========================================================================
// Magnitude compare: registers whether |value| is within a width.
// ==========================================================================
module mag_within_width (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        sample,
    input  wire [16:0] value,
    input  wire [7:0]  width,
    output reg         withinReg
);

    wire [16:0] magnitude;
    wire        withinNext;

    // Two's complement magnitude of a signed 17-bit value.
    assign magnitude  = value[16] ? (~value + 17'h00001) : value;
    // The width itself still counts as coincidence.
    assign withinNext = (magnitude <= {9'h000, width});

    // The result is held between control-cycle samples.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            withinReg <= 1'b0;
        end
        else if (sample)
        begin
            withinReg <= withinNext;
        end
    end

endmodule // mag_within_width

`default_nettype wire

/* src/servo_status_core.v */
// Functional notes
// (R1) Enable low energises motor, references followed.
// (R2) Enable high keeps motor off, references ignored.
// (R3) Mapping 0 takes motor state from pin.
// (R4) Mapping 7 forces motor permanently on.
// (R5) Host stops motion by references, not enable.
// (R6) Position mode: done while error within width.
// (R7) Position width 0 to 250, reset 7.
// (R8) Speed mode: match while speed difference within width.
// (R9) Speed width 0 to 100, reset 10.
// (R10) Factory pair shows done or match by mode.
// (R11) Factory pair held asserted in torque mode.
// (R12) Selection 3211 puts done on first pair.
// (R13) Shared pair drives OR of allocated signals.
// (R14) Compare magnitudes, update once per control cycle.
//
// The address map and strobed register access were left to the implementer.
`include "servo_status_defs.vh"
`default_nettype none

// ==========================================================================
// Servo enable sequencing and completion status outputs.
// ==========================================================================
module servo_status_core (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [15:0] regRdData,
    input  wire        enableInN,
    input  wire        controlTick,
    input  wire [15:0] posError,
    input  wire [15:0] speedRef,
    input  wire [15:0] speedActual,
    input  wire        runningIn,
    input  wire        readyIn,
    output reg         motorOn,
    output reg  [15:0] speedCmdOut,
    output reg         positionDoneOutN,
    output reg         speedMatchOutN,
    output reg  [2:0]  pairOutN
);

    // ======================================================================
    // Declarations.
    // ======================================================================
    reg  [1:0]  modeReg;
    reg  [3:0]  mapReg;
    reg  [7:0]  posWidthReg;
    reg  [6:0]  spdWidthReg;
    reg  [15:0] outSelReg;
    reg         enSync1Reg;
    reg         enSync2Reg;
    reg         tickDlyReg;
    reg         motorOnNext;
    reg  [7:0]  posWidthNext;
    reg  [6:0]  spdWidthNext;
    reg  [15:0] rdNext;
    wire [16:0] posErrExt;
    wire [16:0] speedDiff;
    wire        posWithin;
    wire        spdWithin;
    wire        posDoneStat;
    wire        spdMatchStat;
    wire [3:0]  srcStat;
    wire [2:0]  pairActive;

    // ======================================================================
    // Enable pin synchroniser.
    // ======================================================================

    // The enable pin is asynchronous, so it passes two flip-flops first.
    // An open pin pulls high, which reads as deasserted.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            enSync1Reg <= 1'b1;
            enSync2Reg <= 1'b1;
        end
        else
        begin
            enSync1Reg <= enableInN;
            enSync2Reg <= enSync1Reg;
        end
    end

    // ======================================================================
    // Motor on/off decision.
    // ======================================================================

    // The mapping chooses between the pin and a permanent enable.
    // Unlisted mapping codes keep the motor off as a safe default.
    always @*
    begin
        case (mapReg)
            `MAP_PIN:
            begin
                motorOnNext = ~enSync2Reg; // [R1] [R2] [R3]
            end
            `MAP_FORCED_ON:
            begin
                motorOnNext = 1'b1; // [R4]
            end
            default:
            begin
                motorOnNext = 1'b0;
            end
        endcase
    end

    // The drive state and the gated speed command are registered.
    // While the motor is off, references never reach the drive.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            motorOn     <= 1'b0;
            speedCmdOut <= 16'h0000;
        end
        else
        begin
            motorOn <= motorOnNext; // [R1] [R2]
            if (motorOnNext)
            begin
                speedCmdOut <= speedRef; // [R1]
            end
            else
            begin
                speedCmdOut <= 16'h0000; // [R2]
            end
        end
    end

    // ======================================================================
    // Width limits on write.
    // ======================================================================

    // Writes above the range saturate so the width never leaves it.
    always @*
    begin
        if (regWrData[7:0] > `MAX_POS_WIDTH)
        begin
            posWidthNext = `MAX_POS_WIDTH; // [R7]
        end
        else
        begin
            posWidthNext = regWrData[7:0];
        end
        if (regWrData[7:0] > {1'b0, `MAX_SPD_WIDTH})
        begin
            spdWidthNext = `MAX_SPD_WIDTH; // [R9]
        end
        else
        begin
            spdWidthNext = regWrData[6:0];
        end
    end

    // ======================================================================
    // Register writes.
    // ======================================================================

    // Each write strobe updates the addressed register only.
    // Writes to the status offset or unmapped offsets are ignored.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            modeReg     <= `RST_MODE;
            mapReg      <= `RST_MAP;       // [R3]
            posWidthReg <= `RST_POS_WIDTH; // [R7]
            spdWidthReg <= `RST_SPD_WIDTH; // [R9]
            outSelReg   <= `RST_OUT_SEL;   // [R12]
        end
        else if (regWr)
        begin
            case (regAddr)
                `OFS_CTRL:
                begin
                    modeReg <= regWrData[`CTRL_MODE_HI:`CTRL_MODE_LO];
                    mapReg  <= regWrData[`CTRL_MAP_HI:`CTRL_MAP_LO];
                end
                `OFS_POS_WIDTH:
                begin
                    posWidthReg <= posWidthNext; // [R7]
                end
                `OFS_SPD_WIDTH:
                begin
                    spdWidthReg <= spdWidthNext; // [R9]
                end
                `OFS_OUT_SEL:
                begin
                    outSelReg <= regWrData;
                end
                default:
                begin
                    outSelReg <= outSelReg;
                end
            endcase
        end
    end

    // ======================================================================
    // Register reads.
    // ======================================================================

    // Read data for the addressed register, zero for unmapped offsets.
    always @*
    begin
        rdNext = 16'h0000;
        case (regAddr)
            `OFS_CTRL:
            begin
                rdNext[`CTRL_MODE_HI:`CTRL_MODE_LO] = modeReg;
                rdNext[`CTRL_MAP_HI:`CTRL_MAP_LO]   = mapReg;
            end
            `OFS_POS_WIDTH:
            begin
                rdNext[7:0] = posWidthReg;
            end
            `OFS_SPD_WIDTH:
            begin
                rdNext[6:0] = spdWidthReg;
            end
            `OFS_OUT_SEL:
            begin
                rdNext = outSelReg;
            end
            `OFS_STATUS:
            begin
                rdNext[0]   = motorOn;
                rdNext[1]   = posWithin;
                rdNext[2]   = spdWithin;
                rdNext[3]   = ~enSync2Reg;
                rdNext[6:4] = ~pairOutN;
            end
            default:
            begin
                rdNext = 16'h0000;
            end
        endcase
    end

    // Read data stand for exactly the cycle after the read strobe.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            regRdData <= 16'h0000;
        end
        else if (regRd)
        begin
            regRdData <= rdNext;
        end
        else
        begin
            regRdData <= 16'h0000;
        end
    end

    // ======================================================================
    // Error magnitude comparison.
    // ======================================================================

    // Sign extension keeps the speed difference from overflowing.
    assign posErrExt = {posError[15], posError};
    assign speedDiff = {speedRef[15], speedRef} - {speedActual[15], speedActual};

    // Position error against the position-done width, once per cycle.
    mag_within_width posCmp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .sample    (controlTick), // [R14]
        .value     (posErrExt),   // [R6]
        .width     (posWidthReg),
        .withinReg (posWithin)
    );

    // Speed difference against the speed-match width, once per cycle.
    mag_within_width spdCmp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .sample    (controlTick), // [R14]
        .value     (speedDiff),   // [R8]
        .width     ({1'b0, spdWidthReg}),
        .withinReg (spdWithin)
    );

    // ======================================================================
    // Mode qualification of the status signals.
    // ======================================================================

    // Each status is live in its own mode and held on in torque mode.
    // Sharing a pair by OR thus shows whichever one the mode selects.
    assign posDoneStat  = (modeReg == `MODE_TORQUE) |
                          ((modeReg == `MODE_POSITION) & posWithin); // [R6] [R11]
    assign spdMatchStat = (modeReg == `MODE_TORQUE) |
                          ((modeReg == `MODE_SPEED) & spdWithin); // [R8] [R11]

    // Sources in nibble order of the output selection register.
    assign srcStat = {readyIn, runningIn, spdMatchStat, posDoneStat};

    // ======================================================================
    // Output pair allocation.
    // ======================================================================

    // A pair is active when any source allocated to it is active.
    // Nibble value zero leaves a source unallocated.
    genvar p;
    generate
        for (p = 0; p < `OUT_PAIRS; p = p + 1)
        begin : pairGen
            assign pairActive[p] =
                ((outSelReg[3:0]   == (p + 1)) & srcStat[0]) |
                ((outSelReg[7:4]   == (p + 1)) & srcStat[1]) |
                ((outSelReg[11:8]  == (p + 1)) & srcStat[2]) |
                ((outSelReg[15:12] == (p + 1)) & srcStat[3]); // [R10] [R12] [R13]
        end
    endgenerate

    // ======================================================================
    // Status output registers.
    // ======================================================================

    // Outputs follow the compare results one cycle after the sample.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            tickDlyReg <= 1'b0;
        end
        else
        begin
            tickDlyReg <= controlTick;
        end
    end

    // All status outputs are active low and change once per cycle.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            positionDoneOutN <= 1'b1;
            speedMatchOutN   <= 1'b1;
            pairOutN         <= 3'h7;
        end
        else if (tickDlyReg)
        begin
            positionDoneOutN <= ~posDoneStat;  // [R6] [R14]
            speedMatchOutN   <= ~spdMatchStat; // [R8] [R14]
            pairOutN         <= ~pairActive;   // [R10] [R13]
        end
    end

endmodule // servo_status_core

`default_nettype wire

/* src/servo_status_defs.vh */
`ifndef SERVO_STATUS_DEFS_VH
`define SERVO_STATUS_DEFS_VH

// ==========================================================================
// Register offsets on the plain register port.
// ==========================================================================
`define OFS_CTRL        4'h0
`define OFS_POS_WIDTH   4'h1
`define OFS_SPD_WIDTH   4'h2
`define OFS_OUT_SEL     4'h3
`define OFS_STATUS      4'h4

// ==========================================================================
// Field positions and reset values.
// ==========================================================================
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_MAP_LO     4
`define CTRL_MAP_HI     7
`define RST_MODE        2'h1
`define RST_MAP         4'h0
`define RST_POS_WIDTH   8'h07
`define RST_SPD_WIDTH   7'h0a
`define RST_OUT_SEL     16'h3211
`define MAX_POS_WIDTH   8'hfa
`define MAX_SPD_WIDTH   7'h64

// ==========================================================================
// Control modes and enable mappings.
// ==========================================================================
`define MODE_SPEED      2'h0
`define MODE_POSITION   2'h1
`define MODE_TORQUE     2'h2
`define MAP_PIN         4'h0
`define MAP_FORCED_ON   4'h7

// ==========================================================================
// Output selection layout: one nibble per status source.
// ==========================================================================
`define SEL_NIB_W       4
`define SEL_SOURCES     4
`define OUT_PAIRS       3

`endif
